/* File: tmsr_top.v */
/*
 * mode control and result readout of a three-pad touch sensor.
 * assumes byte register accesses decoded by an i2c slave outside:
 * one-cycle write/read strobes with address and data, all on mclk_i.
 */
`include "tmsr_defines.vh"

module tmsr_top (
    // clock, reset, enable
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    // register access from the i2c slave
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // measurement engine
    input wire sample_i,
    input wire [29:0] readings_i,
    input wire [29:0] touch_levels_i,
    input wire [29:0] release_levels_i,
    input wire overcurrent_i,
    // shared irq / third pad pin
    input wire shared_irq_pad_pin_i,
    output reg shared_irq_pad_pin_o,
    output reg shared_irq_pad_pin_oe_o,
    // analog control
    output reg [2:0] pad_active_o,
    output reg pads_merged_o,
    output reg baseline_cal_freeze_o,
    output reg running_o
);

    reg [7:0] config_r;
    reg overcurrent_flag_r;
    reg irq_latched_r;
    reg [2:0] status_prev_r;
    reg [3:0] en_nxt;
    reg [2:0] pads_nxt;
    reg irq_mode_nxt;
    reg [7:0] rdata_nxt;
    wire [2:0] touched;
    wire [29:0] data_flat;
    wire [3:0] en_field;
    wire [7:0] status_word;
    wire wr_config;
    wire wr_status;

    assign en_field = config_r[`TMSR_ENABLE_HI:`TMSR_ENABLE_LO];
    assign wr_config = reg_wr_i && reg_addr_i == `TMSR_ADDR_CONFIG;
    assign wr_status = reg_wr_i && reg_addr_i == `TMSR_ADDR_STATUS;

    // pad enables and shared pin role from the enable field
    always @* begin
        en_nxt = en_field;
        case (en_nxt)
            `TMSR_EN_STOP: begin
                pads_nxt = `TMSR_PADS_NONE;
                irq_mode_nxt = 1'b1;
            end
            `TMSR_EN_ONE: begin
                pads_nxt = `TMSR_PADS_ONE;
                irq_mode_nxt = 1'b1;
            end
            `TMSR_EN_TWO: begin
                pads_nxt = `TMSR_PADS_TWO;
                irq_mode_nxt = 1'b1;
            end
            default: begin
                pads_nxt = `TMSR_PADS_ALL;
                irq_mode_nxt = 1'b0;
            end
        endcase
    end

    // per-pad channels
    genvar g;
    generate
        for (g = 0; g < `TMSR_NPADS; g = g + 1) begin : chan
            tmsr_pad_channel u_chan (
                .mclk_i(mclk_i),
                .rstn_i(rstn_i),
                .ce_i(ce_i),
                .enable_i(pad_active_o[g]),
                .clear_i(overcurrent_flag_r),
                .sample_i(sample_i),
                .reading_i(readings_i[g*`TMSR_DATA_W +: `TMSR_DATA_W]),
                .touch_level_i(
                    touch_levels_i[g*`TMSR_DATA_W +: `TMSR_DATA_W]),
                .release_level_i(
                    release_levels_i[g*`TMSR_DATA_W +: `TMSR_DATA_W]),
                .touched_o(touched[g]),
                .data_o(data_flat[g*`TMSR_DATA_W +: `TMSR_DATA_W])
            );
        end
    endgenerate

    // status word; disabled pads already read zero
    assign status_word = {overcurrent_flag_r, `TMSR_STATUS_SPARE,
        touched};

    // configuration register and overcurrent flag
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            config_r <= `TMSR_CONFIG_RESET;
            overcurrent_flag_r <= 1'b0;
        end else if (ce_i) begin
            if (overcurrent_i) begin
                overcurrent_flag_r <= 1'b1;
                config_r[`TMSR_ENABLE_HI:`TMSR_ENABLE_LO] <= `TMSR_EN_STOP;
            end else begin
                if (wr_status && reg_wdata_i[`TMSR_BIT_OVERCURRENT])
                    overcurrent_flag_r <= 1'b0;
                if (wr_config) begin
                    // run entry refused while the flag stands
                    if (overcurrent_flag_r)
                        config_r <= {1'b0,
                            reg_wdata_i[`TMSR_BIT_CAL_FREEZE:`TMSR_VARIANT_LO],
                            `TMSR_EN_STOP};
                    else
                        config_r <= reg_wdata_i & `TMSR_CONFIG_WMASK;
                end
            end
        end
    end

    // interrupt: latch on any change of the touched bits, release on any read in a cycle without one
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_latched_r <= 1'b0;
            status_prev_r <= `TMSR_PADS_NONE;
        end else if (ce_i) begin
            status_prev_r <= touched;
            if (touched != status_prev_r)
                irq_latched_r <= 1'b1;
            else if (reg_rd_i)
                irq_latched_r <= 1'b0;
        end
    end

    // read data mux
    always @* begin
        case (reg_addr_i)
            `TMSR_ADDR_STATUS: rdata_nxt = status_word;
            `TMSR_ADDR_P0_LO:
                rdata_nxt = data_flat[`TMSR_P0_LSB +: `TMSR_LO_W];
            `TMSR_ADDR_P0_HI:
                rdata_nxt = {`TMSR_HI_PAD,
                    data_flat[`TMSR_P0_LSB + `TMSR_LO_W +: `TMSR_HI_W]};
            `TMSR_ADDR_P1_LO:
                rdata_nxt = data_flat[`TMSR_P1_LSB +: `TMSR_LO_W];
            `TMSR_ADDR_P1_HI:
                rdata_nxt = {`TMSR_HI_PAD,
                    data_flat[`TMSR_P1_LSB + `TMSR_LO_W +: `TMSR_HI_W]};
            `TMSR_ADDR_P2_LO:
                rdata_nxt = data_flat[`TMSR_P2_LSB +: `TMSR_LO_W];
            `TMSR_ADDR_P2_HI:
                rdata_nxt = {`TMSR_HI_PAD,
                    data_flat[`TMSR_P2_LSB + `TMSR_LO_W +: `TMSR_HI_W]};
            `TMSR_ADDR_CONFIG: rdata_nxt = config_r;
            default: rdata_nxt = `TMSR_ZERO8;
        endcase
    end

    // registered outputs
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= `TMSR_ZERO8;
            shared_irq_pad_pin_o <= 1'b0;
            shared_irq_pad_pin_oe_o <= 1'b0;
            pad_active_o <= `TMSR_PADS_NONE;
            pads_merged_o <= 1'b0;
            baseline_cal_freeze_o <= 1'b0;
            running_o <= 1'b0;
        end else if (ce_i) begin
            if (reg_rd_i)
                reg_rdata_o <= rdata_nxt;
            shared_irq_pad_pin_o <= 1'b0; // open drain pulls low only
            shared_irq_pad_pin_oe_o <= irq_mode_nxt && irq_latched_r;
            pad_active_o <= pads_nxt;
            // variant ignored in stop mode
            pads_merged_o <= (en_field != `TMSR_EN_STOP) &&
                (config_r[`TMSR_VARIANT_HI:`TMSR_VARIANT_LO] !=
                 `TMSR_VARIANT_SEPARATE);
            baseline_cal_freeze_o <= config_r[`TMSR_BIT_CAL_FREEZE];
            running_o <= en_field != `TMSR_EN_STOP;
        end
    end

endmodule

/* File: tmsr_defines.vh */
/*
 * constants for the touch mode and status readout block: register
 * addresses, field positions, reset values and encodings.
 * assumes inclusion by bare name from the design files.
 */
`ifndef TMSR_DEFINES_VH
`define TMSR_DEFINES_VH

`define TMSR_ADDR_STATUS 8'h00
`define TMSR_ADDR_P0_LO 8'h02
`define TMSR_ADDR_P0_HI 8'h03
`define TMSR_ADDR_P1_LO 8'h04
`define TMSR_ADDR_P1_HI 8'h05
`define TMSR_ADDR_P2_LO 8'h06
`define TMSR_ADDR_P2_HI 8'h07
`define TMSR_ADDR_CONFIG 8'h44

`define TMSR_CONFIG_RESET 8'h00
`define TMSR_CONFIG_WMASK 8'h7f
`define TMSR_BIT_CAL_FREEZE 6
`define TMSR_VARIANT_HI 5
`define TMSR_VARIANT_LO 4
`define TMSR_ENABLE_HI 3
`define TMSR_ENABLE_LO 0
`define TMSR_BIT_OVERCURRENT 7

`define TMSR_EN_STOP 4'h0
`define TMSR_EN_ONE 4'h1
`define TMSR_EN_TWO 4'h2
`define TMSR_VARIANT_SEPARATE 2'h0

`define TMSR_NPADS 3
`define TMSR_DATA_W 10
`define TMSR_ZERO8 8'h00
`define TMSR_ZERO10 10'h000

`define TMSR_PADS_NONE 3'h0
`define TMSR_PADS_ONE 3'h1
`define TMSR_PADS_TWO 3'h3
`define TMSR_PADS_ALL 3'h7
`define TMSR_STATUS_SPARE 4'h0
`define TMSR_HI_PAD 6'h00
`define TMSR_LO_W 8
`define TMSR_HI_W 2
`define TMSR_P0_LSB 0
`define TMSR_P1_LSB 10
`define TMSR_P2_LSB 20

`endif

/* File: tmsr_pad_channel.v */
/*
 * one pad channel: hysteresis touch decision and filtered data hold.
 * assumes reading/threshold inputs synchronous to mclk_i.
 */
`include "tmsr_defines.vh"

module tmsr_pad_channel (
    // clock, reset, enable
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    // control
    input wire enable_i,
    input wire clear_i,
    // measurement
    input wire sample_i,
    input wire [9:0] reading_i,
    input wire [9:0] touch_level_i,
    input wire [9:0] release_level_i,
    // results
    output reg touched_o,
    output reg [9:0] data_o
);

    // a touch lowers the reading; hysteresis between two levels
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            touched_o <= 1'b0;
            data_o <= `TMSR_ZERO10;
        end else if (ce_i) begin
            if (clear_i || !enable_i) begin
                touched_o <= 1'b0;
                data_o <= `TMSR_ZERO10;
            end else if (sample_i) begin
                data_o <= reading_i;
                if (!touched_o && reading_i <= touch_level_i)
                    touched_o <= 1'b1;
                else if (touched_o && reading_i >= release_level_i)
                    touched_o <= 1'b0;
            end
        end
    end

endmodule

/* File: tmsr_top_sva.sv */
/* checker for the mode and readout block.
   assumes ce_i held high and ports seen through bind. */
module tmsr_top_sva (
    // clock, reset, enable
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    // register access
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    // measurement engine
    input wire sample_i,
    input wire [29:0] readings_i,
    input wire [29:0] touch_levels_i,
    input wire [29:0] release_levels_i,
    input wire overcurrent_i,
    // shared pin and analog control
    input wire shared_irq_pad_pin_i,
    input wire shared_irq_pad_pin_o,
    input wire shared_irq_pad_pin_oe_o,
    input wire [2:0] pad_active_o,
    input wire pads_merged_o,
    input wire baseline_cal_freeze_o,
    input wire running_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic [2:0] quiet_r;
    wire cfg_wr = reg_wr_i && reg_addr_i == 8'h44;
    wire [3:0] en = reg_wdata_i[3:0];
    wire [2:0] sel_exp = en == 4'h1 ? 3'h1 : (en == 4'h2 ? 3'h3 : 3'h7);
    // cycles since anything that may set the irq latch
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i)
            quiet_r <= 3'h0;
        else if (sample_i || overcurrent_i || reg_wr_i)
            quiet_r <= 3'h0;
        else if (quiet_r != 3'h7)
            quiet_r <= quiet_r + 3'h1;
    end
    stop_cfg_a: assert property (
        cfg_wr && en == 4'h0 |-> ##2 !running_o)
        else $error("stop write left run mode on");
    ovc_stop_a: assert property (
        overcurrent_i ##1 overcurrent_i |-> ##2 !running_o)
        else $error("overcurrent did not stop");
    refuse_run_a: assert property (
        $past(overcurrent_i) && cfg_wr |-> ##2 !running_o)
        else $error("run entered with flag set");
    cal_freeze_a: assert property (
        cfg_wr && !overcurrent_i |->
        ##2 baseline_cal_freeze_o == $past(reg_wdata_i[6], 2))
        else $error("freeze output wrong");
    variant_sel_a: assert property (
        cfg_wr ##2 running_o |->
        pads_merged_o == ($past(reg_wdata_i[5:4], 2) != 2'h0))
        else $error("merged output wrong");
    pad_sel_a: assert property (
        cfg_wr ##2 running_o |-> pad_active_o == $past(sel_exp, 2))
        else $error("active pads wrong");
    pin_role_a: assert property (
        pad_active_o == 3'h7 |-> !shared_irq_pad_pin_oe_o)
        else $error("irq driven in three pad mode");
    rd_release_a: assert property (
        reg_rd_i && quiet_r == 3'h7 |-> ##2 !shared_irq_pad_pin_oe_o)
        else $error("read did not release irq");
    pin_low_a: assert property (
        shared_irq_pad_pin_oe_o |-> !shared_irq_pad_pin_o)
        else $error("irq pin driven high");
    status_zero_a: assert property (
        reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[6:3] == 4'h0)
        else $error("status spare bits set");
    hi_bits_a: assert property (
        reg_rd_i && reg_addr_i[7:3] == 5'h0 && reg_addr_i[0] |=>
        reg_rdata_o[7:2] == 6'h0)
        else $error("high register upper bits set");
    cover property (cfg_wr ##2 running_o);
    cover property (shared_irq_pad_pin_oe_o ##1 !shared_irq_pad_pin_oe_o);
    cover property (overcurrent_i ##1 overcurrent_i);
    cover property ($past(overcurrent_i) && cfg_wr);
endmodule

/* File: tmsr_host_model.sv */
/* host model: register writes and reads as one-cycle strobes.
   assumes the device takes strobes on the rising clock edge. */
module tmsr_host_model (
    // clock and read data
    input wire mclk_i,
    input wire [7:0] reg_rdata_i,
    // strobes and bus
    output logic reg_wr_o = 1'b0,
    output logic reg_rd_o = 1'b0,
    output logic [7:0] reg_addr_o = 8'h00,
    output logic [7:0] reg_wdata_o = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // one write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge mclk_i);
        reg_wr_o = 1'b0;
    endtask
    // one read strobe, data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge mclk_i);
        reg_rd_o = 1'b0;
        @(negedge mclk_i);
        d = reg_rdata_i;
    endtask
    // configuration always passes through stop
    task automatic cfg(input logic [7:0] d);
        wr(8'h44, 8'h00);
        wr(8'h44, d);
    endtask
endmodule

/* File: testbench.sv */
/* bench for the mode and readout block.
   assumes the host model drives register strobes. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, rstn_i = 0, sample_i = 0, overcurrent_i = 0;
    logic [29:0] rv = {10'h3c3, 10'h35a, 10'h2a5};
    logic reg_wr_i, reg_rd_i, oe, pin, run, mrg, frz;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v;
    logic [2:0] act;
    int n_fail = 0, num_checks = 0, cyc = 0;
    wire [7:0] ctl = {run, mrg, frz, act, pin, oe};
    initial forever #25 mclk_i = ~mclk_i;
    // cycle ceiling
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end
    tmsr_top DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .sample_i(sample_i), .readings_i(rv),
        .touch_levels_i({3{10'h100}}), .release_levels_i({3{10'h200}}),
        .overcurrent_i(overcurrent_i), .shared_irq_pad_pin_i(1'b1),
        .shared_irq_pad_pin_o(pin), .shared_irq_pad_pin_oe_o(oe),
        .pad_active_o(act), .pads_merged_o(mrg),
        .baseline_cal_freeze_o(frz), .running_o(run));
    tmsr_host_model host (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk(v, e);
    endtask
    task automatic pulse(input logic [29:0] r);
        @(negedge mclk_i);
        rv = r;
        sample_i = 1'b1;
        @(negedge mclk_i);
        sample_i = 1'b0;
        repeat (8) @(negedge mclk_i);
    endtask
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_fail, num_checks);
        if (n_fail == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge mclk_i);
        rstn_i = 1'b1;
        chk(ctl, 8'h00);
        rchk(8'h44, 8'h00);
        host.cfg(8'h03);
        pulse(rv);
        chk(ctl, 8'h9c);
        for (int i = 0; i < 3; i++) begin
            rchk(8'h02 + 8'(2 * i), rv[10 * i +: 8]);
            rchk(8'h03 + 8'(2 * i), {6'h0, rv[10 * i + 8 +: 2]});
        end
        host.cfg(8'h01);
        pulse({3{10'h050}});
        chk(ctl, 8'h85);
        rchk(8'h00, 8'h01);
        repeat (2) @(negedge mclk_i);
        chk(ctl, 8'h84);
        pulse({3{10'h3ff}});
        chk(ctl, 8'h85);
        rchk(8'h00, 8'h00);
        host.cfg(8'h72);
        repeat (2) @(negedge mclk_i);
        chk(ctl, 8'hec);
        host.wr(8'h44, 8'h00);
        @(negedge mclk_i);
        overcurrent_i = 1'b1;
        host.wr(8'h44, 8'h01);
        overcurrent_i = 1'b0;
        rchk(8'h02, 8'h00);
        rchk(8'h00, 8'h80);
        host.wr(8'h44, 8'h01);
        repeat (2) @(negedge mclk_i);
        chk(ctl & 8'h80, 8'h00);
        host.wr(8'h00, 8'h80);
        rchk(8'h00, 8'h00);
        host.wr(8'h44, 8'h01);
        repeat (2) @(negedge mclk_i);
        chk(ctl & 8'h80, 8'h80);
        rchk(8'h01, 8'h00);
        summarize();
    end
endmodule
bind tmsr_top tmsr_top_sva chk_i (.*);
